// *** rtl/mdio_frame.sv ***
`timescale 1ns/1ps
`include "xcvr_ctl_consts.svh"

// Serial management frame engine: preamble, header, turnaround and data.
module mdio_frame
  import xcvr_ctl_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = `PHY_ADDR_DEFAULT
) (
  input wire logic i_clk, // System clock.
  input wire logic i_rst_n, // Synchronous reset, active low.
  input wire logic i_ce, // Clock enable.
  input wire logic i_mdc, // Synchronised management clock level.
  input wire logic i_mdio, // Synchronised data pin level.
  output logic o_mdio, // Data pin output value.
  output logic o_mdio_oe, // Data pin output enable, high while driving.
  mgmt_if.frame bus // Register access side.
);

  frame_state_e state_r;
  logic mdc_q_r;
  logic rise;
  logic [5:0] cnt_r;
  logic [11:0] hdr_r;
  logic [12:0] hdr_full;
  logic [15:0] sh_r;
  logic is_read_r;
  logic [4:0] addr_r;
  logic wr_stb_r;
  logic rise_r;
  logic [15:0] wdata_r;

  // Edge detect and the register-side outputs.
  assign rise = i_mdc & ~mdc_q_r;
  assign hdr_full = {hdr_r, i_mdio};
  assign bus.mdc_rise = rise_r;
  assign bus.wr_stb = wr_stb_r;
  assign bus.addr = addr_r;
  assign bus.wdata = wdata_r;

  // Frame sequencer; advances on each rising MDC edge.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_r <= ST_PRE;
      mdc_q_r <= 1'b0;
      cnt_r <= 6'd0;
      hdr_r <= 12'h000;
      sh_r <= 16'h0000;
      is_read_r <= 1'b0;
      addr_r <= 5'h00;
      wr_stb_r <= 1'b0;
      rise_r <= 1'b0;
      wdata_r <= 16'h0000;
      o_mdio <= 1'b0;
      o_mdio_oe <= 1'b0;
    end else if (i_ce) begin
      mdc_q_r <= i_mdc;
      rise_r <= rise;
      wr_stb_r <= 1'b0;
      if (rise) begin
        case (state_r)
          ST_PRE: begin
            if (i_mdio) begin
              if (cnt_r != `PREAMBLE_BITS) begin
                cnt_r <= cnt_r + 6'd1;
              end
            end else if (cnt_r == `PREAMBLE_BITS) begin
              state_r <= ST_HDR;
              cnt_r <= 6'd0;
            end else begin
              cnt_r <= 6'd0;
            end
          end
          ST_HDR: begin
            hdr_r <= hdr_full[11:0];
            cnt_r <= cnt_r + 6'd1;
            if (cnt_r == `HDR_BITS - 6'd1) begin
              cnt_r <= 6'd0;
              if (hdr_full[12] && hdr_full[9:5] == PHY_ADDR &&
                  (hdr_full[11:10] == `OP_READ || hdr_full[11:10] == `OP_WRITE)) begin
                state_r <= ST_TA;
                is_read_r <= (hdr_full[11:10] == `OP_READ);
                addr_r <= hdr_full[4:0];
              end else begin
                state_r <= ST_PRE;
              end
            end
          end
          ST_TA: begin
            if (is_read_r) begin
              o_mdio <= 1'b0;
              o_mdio_oe <= 1'b1;
              sh_r <= bus.rdata;
              state_r <= ST_DATA;
              cnt_r <= 6'd0;
            end else if (cnt_r == `TA_BITS - 6'd1) begin
              state_r <= ST_DATA;
              cnt_r <= 6'd0;
            end else begin
              cnt_r <= cnt_r + 6'd1;
            end
          end
          ST_DATA: begin
            if (is_read_r) begin
              if (cnt_r == `DATA_BITS) begin
                o_mdio_oe <= 1'b0;
                state_r <= ST_PRE;
                cnt_r <= 6'd0;
              end else begin
                o_mdio <= sh_r[15];
                sh_r <= {sh_r[14:0], 1'b0};
                cnt_r <= cnt_r + 6'd1;
              end
            end else begin
              sh_r <= {sh_r[14:0], i_mdio};
              cnt_r <= cnt_r + 6'd1;
              if (cnt_r == `DATA_BITS - 6'd1) begin
                wr_stb_r <= 1'b1;
                wdata_r <= {sh_r[14:0], i_mdio};
                state_r <= ST_PRE;
                cnt_r <= 6'd0;
              end
            end
          end
          default: begin
            state_r <= ST_PRE;
          end
        endcase
      end
    end
  end

endmodule

// *** rtl/mgmt_if.sv ***
`timescale 1ns/1ps

// Link between the serial frame engine and the register bank.
interface mgmt_if;
  logic mdc_rise;
  logic wr_stb;
  logic [4:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;

  modport frame (output mdc_rise, output wr_stb, output addr, output wdata, input rdata);
  modport regs (input mdc_rise, input wr_stb, input addr, input wdata, output rdata);
endinterface

// *** rtl/pin_sync.sv ***
`timescale 1ns/1ps

// Three-stage synchroniser; output follows once stages two and three agree.
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk, // System clock.
  input wire logic i_rst_n, // Synchronous reset, active low.
  input wire logic i_ce, // Clock enable.
  input wire logic [WIDTH-1:0] i_d, // Asynchronous inputs.
  output logic [WIDTH-1:0] o_q // Filtered synchronous levels.
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic q_r;

      // The first stage feeds only the second stage.
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          q_r <= 1'b0;
        end else if (i_ce) begin
          s1_r <= i_d[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            q_r <= s3_r;
          end
        end
      end

      // Each bit has one driver, its own filtered flop.
      assign o_q[g] = q_r;
    end
  endgenerate

endmodule

// *** rtl/xcvr_ctl_consts.svh ***
`ifndef XCVR_CTL_CONSTS_SVH
`define XCVR_CTL_CONSTS_SVH

// Register addresses on the management bus.
`define REG_BASIC_CTL 5'h00
`define REG_CHAN_ON 5'h10
`define REG_GLOBAL_CTL 5'h11
`define REG_PAIR_AB 5'h12
`define REG_PAIR_CD 5'h13

// Writable bits of each register; all other bits are reserved.
`define MASK_BASIC 16'h8000
`define MASK_CHAN 16'hFF00
`define MASK_GLOBAL 16'hC3F8
`define MASK_PAIR 16'h0FFF

// Reset values.
`define RST_BASIC 16'h0000
`define RST_CHAN 16'hFF00
`define RST_GLOBAL 16'h4380
`define RST_AB 16'h0DBC
`define RST_CD 16'h0C50

// Field positions.
`define BIT_GLOBAL_RESET 15
`define CHAN_HI 15
`define CHAN_LO 8
`define BIT_TX_CLK 15
`define BIT_CODE_ERR 14
`define BIT_PAR_OUT 9
`define BIT_COMMA 8
`define BIT_CODING 7
`define BIT_MODE_BYPASS 6
`define MODE_HI 5
`define MODE_LO 4
`define BIT_SOFT_RESET 3
`define EMPH_HI 11
`define EMPH_LO 10
`define BIT_EMPH_OVR 9
`define FILL_HI 8
`define FILL_LO 0

// Management frame timing in MDC periods, opcodes and default PHY address.
`define PREAMBLE_BITS 6'd32
`define HDR_BITS 6'd13
`define TA_BITS 6'd2
`define DATA_BITS 6'd16
`define OP_READ 2'b10
`define OP_WRITE 2'b01
`define PHY_ADDR_DEFAULT 5'h00

`endif

// *** rtl/xcvr_ctl_pkg.sv ***
package xcvr_ctl_pkg;

  // Management frame states, one-hot.
  typedef enum logic [3:0] {
    ST_PRE = 4'b0001,
    ST_HDR = 4'b0010,
    ST_TA = 4'b0100,
    ST_DATA = 4'b1000
  } frame_state_e;

  typedef logic [15:0] word_t;

endpackage

// *** rtl/xcvr_ctl_regs.sv ***
// Operation
// - Eight channel on bits reset to ones.
// - Channel on equals bit AND enable pin.
// - Reserved bits read zero, writes ignored.
// - Clocking select is bit OR pin.
// - Code error report resets one, ORs pin.
// - Parallel outputs need bit and pin high.
// - Comma search bit resets to one.
// - Line coding resets one, ORs pin.
// - Bypass bit selects register mode over pins.
// - Soft reset resets datapath, keeps registers.
// - Soft reset clears on next MDC cycle.
// - Pair emphasis fields reset to high.
// - Pair override replaces global emphasis setting.
// - First fill character resets to K28.5.
// - Second fill character resets to D16.2.
// - Global reset bit ORs pin, self-clears.
`timescale 1ns/1ps
`include "xcvr_ctl_consts.svh"

module xcvr_ctl_regs
  import xcvr_ctl_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = `PHY_ADDR_DEFAULT
) (
  input wire logic i_clk, // 100 MHz clock.
  input wire logic i_rst_n, // Synchronous reset, active low.
  input wire logic i_ce, // Clock enable; freezes state while low.
  input wire logic i_mdc, // Management clock pin.
  input wire logic i_mdio, // Management data pin, input side.
  output logic o_mdio, // Management data pin, output side.
  output logic o_mdio_oe, // Management data pin drive enable.
  input wire logic i_enable_pin, // External enable pin.
  input wire logic i_tx_clocking_select_pin, // External clocking select pin.
  input wire logic i_code_error_report_pin, // External code error report pin.
  input wire logic i_line_coding_pin, // External line coding pin.
  input wire logic [1:0] i_mode_pins, // External mode pins.
  input wire logic i_reset_pin, // External reset pin, active high.
  input wire logic [1:0] i_global_emphasis, // Global emphasis level, same clock.
  output logic [7:0] o_per_channel_on, // Effective per-channel enables.
  output logic o_tx_clocking_select, // 1 = per-channel transmit clocking.
  output logic o_code_error_report_on, // Code and disparity error reporting.
  output logic o_parallel_out_on, // Parallel output enable.
  output logic o_comma_search_on, // Comma alignment enable.
  output logic o_line_coding_on, // 8b/10b coding enable.
  output logic [1:0] o_mode, // Effective interface mode.
  output logic o_datapath_reset, // Receive, transmit and FIFO reset.
  output logic o_fifo_clear, // FIFO clear from global reset.
  output logic [1:0] o_pair_ab_emphasis_level, // Effective emphasis, pair A/B.
  output logic [1:0] o_pair_cd_emphasis_level, // Effective emphasis, pair C/D.
  output logic [8:0] o_first_fill_character, // First idle character.
  output logic [8:0] o_second_fill_character // Second idle character.
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and the frame engine.

  localparam int SYNC_W = 9;

  logic [SYNC_W-1:0] sync_q;
  logic mdc_s;
  logic mdio_s;
  logic en_s;
  logic tclk_s;
  logic cv_s;
  logic code_s;
  logic [1:0] mode_s;
  logic pin_rst_s;
  logic clr;

  mgmt_if bus ();

  pin_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_d({i_reset_pin, i_mode_pins, i_line_coding_pin, i_code_error_report_pin,
          i_tx_clocking_select_pin, i_enable_pin, i_mdio, i_mdc}),
    .o_q(sync_q)
  );

  // Split the synchronised pin vector.
  assign mdc_s = sync_q[0];
  assign mdio_s = sync_q[1];
  assign en_s = sync_q[2];
  assign tclk_s = sync_q[3];
  assign cv_s = sync_q[4];
  assign code_s = sync_q[5];
  assign mode_s = sync_q[7:6];
  assign pin_rst_s = sync_q[8];
  assign clr = !i_rst_n || pin_rst_s;

  mdio_frame #(
    .PHY_ADDR(PHY_ADDR)
  ) u_frame (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_mdc(mdc_s),
    .i_mdio(mdio_s),
    .o_mdio(o_mdio),
    .o_mdio_oe(o_mdio_oe),
    .bus(bus.frame)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register storage. Only writable bits are stored, so reserved bits stay zero.

  word_t basic_r;
  word_t chan_r;
  word_t glob_r;
  word_t ab_r;
  word_t cd_r;

  // Global reset bit; cleared on the next MDC edge, a write in that cycle wins.
  always_ff @(posedge i_clk) begin
    if (clr) begin
      basic_r <= `RST_BASIC;
    end else if (i_ce) begin
      if (bus.wr_stb && bus.addr == `REG_BASIC_CTL) begin
        basic_r <= bus.wdata & `MASK_BASIC;
      end else if (bus.mdc_rise) begin
        basic_r[`BIT_GLOBAL_RESET] <= 1'b0;
      end
    end
  end

  // Channel on bits; the pin reset restores all ones.
  always_ff @(posedge i_clk) begin
    if (clr) begin
      chan_r <= `RST_CHAN;
    end else if (i_ce && bus.wr_stb && bus.addr == `REG_CHAN_ON) begin
      chan_r <= bus.wdata & `MASK_CHAN;
    end
  end

  // Global datapath control; the soft reset bit self-clears on the next MDC edge.
  always_ff @(posedge i_clk) begin
    if (clr) begin
      glob_r <= `RST_GLOBAL;
    end else if (i_ce) begin
      if (bus.wr_stb && bus.addr == `REG_GLOBAL_CTL) begin
        glob_r <= bus.wdata & `MASK_GLOBAL;
      end else if (bus.mdc_rise) begin
        glob_r[`BIT_SOFT_RESET] <= 1'b0;
      end
    end
  end

  // Pair emphasis, override and fill characters.
  always_ff @(posedge i_clk) begin
    if (clr) begin
      ab_r <= `RST_AB;
      cd_r <= `RST_CD;
    end else if (i_ce && bus.wr_stb) begin
      if (bus.addr == `REG_PAIR_AB) begin
        ab_r <= bus.wdata & `MASK_PAIR;
      end else if (bus.addr == `REG_PAIR_CD) begin
        cd_r <= bus.wdata & `MASK_PAIR;
      end
    end
  end

  // Read mux; unmapped addresses read as zero.
  always_comb begin
    bus.rdata = 16'h0000;
    if (bus.addr == `REG_BASIC_CTL) begin
      bus.rdata = basic_r;
    end else if (bus.addr == `REG_CHAN_ON) begin
      bus.rdata = chan_r;
    end else if (bus.addr == `REG_GLOBAL_CTL) begin
      bus.rdata = glob_r;
    end else if (bus.addr == `REG_PAIR_AB) begin
      bus.rdata = ab_r;
    end else if (bus.addr == `REG_PAIR_CD) begin
      bus.rdata = cd_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective controls, registered; comma search and fill characters use no pin, emphasis uses i_global_emphasis.

  // Channel and global datapath controls.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_per_channel_on <= 8'h00;
      o_tx_clocking_select <= 1'b0;
      o_code_error_report_on <= 1'b0;
      o_parallel_out_on <= 1'b0;
      o_comma_search_on <= 1'b0;
      o_line_coding_on <= 1'b0;
      o_mode <= 2'h0;
    end else if (i_ce) begin
      o_per_channel_on <= chan_r[`CHAN_HI:`CHAN_LO] & {8{en_s}};
      o_tx_clocking_select <= glob_r[`BIT_TX_CLK] | tclk_s;
      o_code_error_report_on <= glob_r[`BIT_CODE_ERR] | cv_s;
      o_parallel_out_on <= glob_r[`BIT_PAR_OUT] & en_s;
      o_comma_search_on <= glob_r[`BIT_COMMA];
      o_line_coding_on <= glob_r[`BIT_CODING] | code_s;
      if (glob_r[`BIT_MODE_BYPASS]) begin
        o_mode <= glob_r[`MODE_HI:`MODE_LO];
      end else begin
        o_mode <= mode_s;
      end
    end
  end

  // Datapath reset and FIFO clear; the registers themselves are left alone.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_datapath_reset <= 1'b1;
      o_fifo_clear <= 1'b1;
    end else if (i_ce) begin
      o_datapath_reset <= pin_rst_s | basic_r[`BIT_GLOBAL_RESET] |
                          glob_r[`BIT_SOFT_RESET];
      o_fifo_clear <= pin_rst_s | basic_r[`BIT_GLOBAL_RESET];
    end
  end

  // Emphasis selection per pair and fill characters.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pair_ab_emphasis_level <= 2'h0;
      o_pair_cd_emphasis_level <= 2'h0;
      o_first_fill_character <= 9'h000;
      o_second_fill_character <= 9'h000;
    end else if (i_ce) begin
      o_pair_ab_emphasis_level <= ab_r[`BIT_EMPH_OVR] ? ab_r[`EMPH_HI:`EMPH_LO] :
                                  i_global_emphasis;
      o_pair_cd_emphasis_level <= cd_r[`BIT_EMPH_OVR] ? cd_r[`EMPH_HI:`EMPH_LO] :
                                  i_global_emphasis;
      o_first_fill_character <= ab_r[`FILL_HI:`FILL_LO];
      o_second_fill_character <= cd_r[`FILL_HI:`FILL_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and coverage.

  default clocking cb @(posedge i_clk);
  endclocking

  default disable iff (!i_rst_n);

  property p_chan_reset;
    !$past(i_rst_n) |-> chan_r == `RST_CHAN;
  endproperty
  a_chan_reset: assert property (p_chan_reset) else $error("channel bits reset wrong");

  property p_chan_and;
    i_ce |=> o_per_channel_on == ($past(chan_r[`CHAN_HI:`CHAN_LO]) & {8{$past(en_s)}});
  endproperty
  a_chan_and: assert property (p_chan_and) else $error("channel enable not ANDed with pin");

  property p_reserved;
    (bus.addr == `REG_CHAN_ON) |-> bus.rdata[7:0] == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");

  property p_tx_clk;
    i_ce |=> o_tx_clocking_select == ($past(glob_r[`BIT_TX_CLK]) | $past(tclk_s));
  endproperty
  a_tx_clk: assert property (p_tx_clk) else $error("clocking select not ORed with pin");

  property p_glob_reset;
    !$past(i_rst_n) |-> glob_r == `RST_GLOBAL;
  endproperty
  a_glob_reset: assert property (p_glob_reset) else $error("global control reset wrong");

  property p_par_out;
    i_ce && !en_s |=> !o_parallel_out_on;
  endproperty
  a_par_out: assert property (p_par_out) else $error("parallel output on with pin low");

  property p_coding;
    i_ce && code_s |=> o_line_coding_on;
  endproperty
  a_coding: assert property (p_coding) else $error("line coding off with pin high");

  property p_mode;
    i_ce && glob_r[`BIT_MODE_BYPASS] |=> o_mode == $past(glob_r[`MODE_HI:`MODE_LO]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode bypass ignored");

  property p_soft_reset;
    i_ce && glob_r[`BIT_SOFT_RESET] && !bus.wr_stb && !pin_rst_s |=>
      o_datapath_reset && chan_r == $past(chan_r);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset action wrong");

  property p_soft_clear;
    i_ce && glob_r[`BIT_SOFT_RESET] && bus.mdc_rise && !bus.wr_stb && !pin_rst_s |=>
      !glob_r[`BIT_SOFT_RESET];
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft reset not self-cleared");

  property p_emph;
    i_ce && ab_r[`BIT_EMPH_OVR] |=> o_pair_ab_emphasis_level == $past(ab_r[`EMPH_HI:`EMPH_LO]);
  endproperty
  a_emph: assert property (p_emph) else $error("pair override ignored");

  property p_fill_reset;
    !$past(i_rst_n) |-> ab_r[`FILL_HI:`FILL_LO] == 9'h1BC && cd_r[`FILL_HI:`FILL_LO] == 9'h050;
  endproperty
  a_fill_reset: assert property (p_fill_reset) else $error("fill characters reset wrong");

  property p_fifo_clear;
    i_ce && basic_r[`BIT_GLOBAL_RESET] |=> o_fifo_clear ##0 o_datapath_reset;
  endproperty
  a_fifo_clear: assert property (p_fifo_clear) else $error("FIFO not cleared");

  property p_dp_release;
    i_ce && !pin_rst_s && !basic_r[`BIT_GLOBAL_RESET] && !glob_r[`BIT_SOFT_RESET] |=>
      !o_datapath_reset;
  endproperty
  a_dp_release: assert property (p_dp_release) else $error("datapath reset stuck");

  c_write_glob: cover property (bus.wr_stb && bus.addr == `REG_GLOBAL_CTL);
  c_soft_reset: cover property (glob_r[`BIT_SOFT_RESET] ##[1:200] !glob_r[`BIT_SOFT_RESET]);
  c_read: cover property ($rose(o_mdio_oe));
  c_chan_off: cover property (o_per_channel_on != 8'hFF && en_s);

endmodule

// *** verif/mdio_station.sv ***
`timescale 1ns/1ps
`include "xcvr_ctl_consts.svh"

// Management station: MDC low for HALF and high for HALF+1 system clocks, idle between frames.
module mdio_station
  import xcvr_ctl_pkg::*;
(
  input wire logic i_clk, // System clock.
  input wire logic i_line, // Resolved data wire.
  output logic o_mdc, // Management clock.
  output logic o_d, // Station data value.
  output logic o_oe // High while station drives the wire.
);
  localparam int HALF = 12;

  // Idle levels at time zero.
  initial begin
    o_mdc = 1'b0;
    o_d = 1'b1;
    o_oe = 1'b0;
  end

  // One bit: data set while MDC is low, wire sampled just before the rise.
  task automatic slot(input logic drv, input logic val, output logic smp);
    @(negedge i_clk);
    o_mdc = 1'b0;
    o_oe = drv;
    o_d = val;
    repeat (HALF) @(negedge i_clk);
    smp = i_line;
    o_mdc = 1'b1;
    repeat (HALF) @(negedge i_clk);
  endtask

  // Whole frame with its own preamble; a read releases the wire from turnaround on.
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input word_t wd, output word_t rd);
    logic [31:0] bits;
    logic s;
    bits = {2'b01, op, phy, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < 32; i++) begin
      slot(1'b1, 1'b1, s);
    end
    for (int i = 31; i >= 0; i--) begin
      slot(op == `OP_WRITE || i > 17, bits[i], s);
      if (i < 16) begin
        rd[i] = s;
      end
    end
    o_oe = 1'b0;
  endtask
endmodule

// *** verif/test_xcvr_ctl_regs.sv ***
`timescale 1ns/1ps
`include "xcvr_ctl_consts.svh"

module test_xcvr_ctl_regs
  import xcvr_ctl_pkg::*;
;
  logic clk;
  logic rst_n;
  logic ce;
  logic mdc;
  logic st_d;
  logic st_oe;
  logic line;
  logic o_mdio;
  logic o_oe;
  logic en;
  logic tcs;
  logic cer;
  logic lc;
  logic [1:0] mode_p;
  logic rpin;
  logic [1:0] gemph;
  logic [7:0] chan_on;
  logic tx_sel;
  logic cer_on;
  logic par_on;
  logic comma_on;
  logic lc_on;
  logic [1:0] mode;
  logic dp_rst;
  logic fifo_clr;
  logic [1:0] ab;
  logic [1:0] cd;
  logic [8:0] fill1;
  logic [8:0] fill2;
  word_t exp_r [4];
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;

  // Pull-up on the data wire when nobody drives it.
  assign line = o_oe ? o_mdio : (st_oe ? st_d : 1'b1);

  xcvr_ctl_regs dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_mdc(mdc), .i_mdio(line),
    .o_mdio(o_mdio), .o_mdio_oe(o_oe), .i_enable_pin(en), .i_tx_clocking_select_pin(tcs),
    .i_code_error_report_pin(cer), .i_line_coding_pin(lc), .i_mode_pins(mode_p),
    .i_reset_pin(rpin), .i_global_emphasis(gemph), .o_per_channel_on(chan_on),
    .o_tx_clocking_select(tx_sel), .o_code_error_report_on(cer_on),
    .o_parallel_out_on(par_on), .o_comma_search_on(comma_on), .o_line_coding_on(lc_on),
    .o_mode(mode), .o_datapath_reset(dp_rst), .o_fifo_clear(fifo_clr),
    .o_pair_ab_emphasis_level(ab), .o_pair_cd_emphasis_level(cd),
    .o_first_fill_character(fill1), .o_second_fill_character(fill2)
  );

  mdio_station st (.i_clk(clk), .i_line(line), .o_mdc(mdc), .o_d(st_d), .o_oe(st_oe));

  // Clock and hang guard.
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Compares one result against the model.
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Stored bits of each modelled register; the soft reset bit never reads back.
  function automatic word_t msk(input logic [1:0] i);
    case (i)
      2'd0: msk = 16'hFF00;
      2'd1: msk = 16'hC3F0;
      default: msk = 16'h0FFF;
    endcase
  endfunction

  task automatic wr(input logic [4:0] ra, input word_t wd);
    word_t d;
    st.frame(`OP_WRITE, `PHY_ADDR_DEFAULT, ra, wd, d);
    if (ra[4:2] == 3'b100) exp_r[ra[1:0]] = wd & msk(ra[1:0]);
  endtask

  task automatic rd_chk(input logic [4:0] ra);
    word_t d;
    word_t e;
    st.frame(`OP_READ, `PHY_ADDR_DEFAULT, ra, 16'h0000, d);
    e = (ra[4:2] == 3'b100) ? exp_r[ra[1:0]] : 16'h0000;
    chk(d, e, "read");
  endtask

  task automatic rd_all();
    for (int a = 0; a < 4; a++) begin
      rd_chk(5'h10 + 5'(a));
    end
  endtask

  // Effective outputs worked out from model registers and pins.
  task automatic outs_chk();
    logic [15:0] g;
    logic [15:0] p;
    logic [15:0] q;
    g = exp_r[1];
    p = exp_r[2];
    q = exp_r[3];
    chk({chan_on, tx_sel, cer_on, par_on, comma_on, lc_on, mode, ab, cd, fill1, fill2},
        {exp_r[0][15:8] & {8{en}}, g[15] | tcs, g[14] | cer, g[9] & en, g[8], g[7] | lc,
         g[6] ? g[5:4] : mode_p, p[9] ? p[11:10] : gemph, q[9] ? q[11:10] : gemph,
         p[8:0], q[8:0]}, "outputs");
  endtask

  task automatic set_pins();
    {en, tcs, cer, lc, mode_p, gemph} = 8'($urandom());
    repeat (10) @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    word_t d;
    rst_n = 1'b0;
    ce = 1'b1;
    {en, tcs, cer, lc, rpin} = 5'h10;
    mode_p = 2'h0;
    gemph = 2'h0;
    exp_r = '{16'hFF00, 16'h4380, 16'h0DBC, 16'h0C50};
    void'($urandom(32'h614CA6BA));
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    outs_chk();
    rd_all();
    rd_chk(`REG_BASIC_CTL);
    rd_chk(5'h05);
    $display("test reset values done");
    for (int i = 0; i < 2; i++) begin
      en = 1'b0;
      for (int a = 0; a < 4; a++) begin
        wr(5'h10 + 5'(a), 16'($urandom()));
      end
      wr(5'h05, 16'($urandom()));
      set_pins();
      outs_chk();
      rd_all();
    end
    $display("test random access done");
    ce = 1'b0;
    en = ~en;
    repeat (10) @(negedge clk);
    chk(chan_on, exp_r[0][15:8] & {8{~en}}, "frozen");
    ce = 1'b1;
    repeat (10) @(negedge clk);
    outs_chk();
    $display("test clock enable done");
    wr(`REG_GLOBAL_CTL, exp_r[1] | 16'h0048);
    chk({dp_rst, fifo_clr}, 2'b10, "soft reset");
    rd_all();
    chk(dp_rst, 1'b0, "soft reset end");
    $display("test soft reset done");
    wr(`REG_BASIC_CTL, 16'h8000);
    chk({dp_rst, fifo_clr}, 2'b11, "global reset");
    rd_chk(`REG_BASIC_CTL);
    chk({dp_rst, fifo_clr}, 2'b00, "global reset end");
    $display("test global reset done");
    st.frame(`OP_WRITE, 5'h1F, `REG_PAIR_AB, 16'h0A55, d);
    rd_chk(`REG_PAIR_AB);
    $display("test foreign address done");
    rpin = 1'b1;
    repeat (10) @(negedge clk);
    chk({dp_rst, fifo_clr}, 2'b11, "reset pin");
    rpin = 1'b0;
    exp_r = '{16'hFF00, 16'h4380, 16'h0DBC, 16'h0C50};
    repeat (10) @(negedge clk);
    outs_chk();
    rd_all();
    $display("test reset pin done");
    conclude();
  end
endmodule
